//--- core/btd_slot_decode.sv
// bundle decoder package and single-slot major opcode decoder
package btd_pkg;
  localparam int BUNDLE_W = 128;
  localparam int TPL_W = 5;
  localparam int SLOT_W = 41;
  localparam int SLOT_COUNT = 3;
  localparam int PR_COUNT = 64;
  localparam int IMM14_W = 14;
  localparam int PAIR_COUNT = 16;
  localparam int SEL_W = 2;
  // bundle and instruction field positions
  localparam int TPL_LO = 0;
  localparam int SLOT0_LO = 5;
  localparam int OPC_HI = 40;
  localparam int OPC_LO = 37;
  localparam int QP_HI = 5;
  localparam int QP_LO = 0;
  localparam int SIGN_BIT = 36;
  localparam int X2A_HI = 35;
  localparam int X2A_LO = 34;
  localparam int IMM6_HI = 32;
  localparam int IMM6_LO = 27;
  localparam int IMM7_HI = 19;
  localparam int IMM7_LO = 13;
  localparam logic [1:0] X2A_ADD_IMM14 = 2'h2;
  localparam logic [SEL_W-1:0] SLOT_SEL_0 = 2'h0;
  localparam logic [SLOT_COUNT-1:0] NO_SLOTS = 3'h0;
  // major opcode values; meaning depends on the unit column
  localparam logic [3:0] MOP_0 = 4'h0, MOP_1 = 4'h1, MOP_2 = 4'h2, MOP_4 = 4'h4, MOP_5 = 4'h5;
  localparam logic [3:0] MOP_6 = 4'h6, MOP_7 = 4'h7, MOP_8 = 4'h8, MOP_9 = 4'h9, MOP_A = 4'hA;
  localparam logic [3:0] MOP_B = 4'hB, MOP_C = 4'hC, MOP_D = 4'hD, MOP_E = 4'hE;
  // unused major ops: ignored in the branch column, reserved in the extended column,
  // reserved-if-guard-true everywhere else
  localparam logic [15:0] UNUSED_IGN_B = 16'hFFC8;
  localparam logic [15:0] UNUSED_RES_X = 16'hFFBE;
  localparam logic [31:0] TPL_RESERVED = 32'hCC30_00C0;

  typedef enum logic [2:0] {UNIT_NONE, UNIT_M, UNIT_I, UNIT_F, UNIT_B, UNIT_L, UNIT_X} btd_unit_e;
  typedef btd_unit_e [SLOT_COUNT-1:0] btd_trio_t;
  typedef enum logic [4:0] {
    OP_NONE, OP_UNUSED, OP_I_MISC, OP_DEPOSIT, OP_SHIFT_TBIT, OP_MM_MPY_SHIFT, OP_ALU, OP_ADD_IMM22,
    OP_COMPARE, OP_MEM_MGMT, OP_INT_LD_REG, OP_INT_LDST_IMM, OP_FP_LDST_REG, OP_FP_LDST_IMM,
    OP_FP_MISC, OP_FP_COMPARE, OP_FP_CLASS, OP_FMA, OP_FMS, OP_FNMA, OP_FSEL_XMA, OP_B_MISC_IND,
    OP_IND_CALL, OP_B_NOP, OP_REL_BRANCH, OP_REL_CALL, OP_LX_MISC, OP_MOVL, OP_LX_PAIR
  } btd_op_e;

  // indexed by template bits 4:1, entries list slot 2, slot 1, slot 0
  localparam btd_trio_t TPL_PAIR_MAP [PAIR_COUNT] = '{
    '{UNIT_I, UNIT_I, UNIT_M}, '{UNIT_I, UNIT_I, UNIT_M}, '{UNIT_X, UNIT_L, UNIT_M},
    '{UNIT_NONE, UNIT_NONE, UNIT_NONE}, '{UNIT_I, UNIT_M, UNIT_M}, '{UNIT_I, UNIT_M, UNIT_M},
    '{UNIT_I, UNIT_F, UNIT_M}, '{UNIT_F, UNIT_M, UNIT_M}, '{UNIT_B, UNIT_I, UNIT_M},
    '{UNIT_B, UNIT_B, UNIT_M}, '{UNIT_NONE, UNIT_NONE, UNIT_NONE}, '{UNIT_B, UNIT_B, UNIT_B},
    '{UNIT_B, UNIT_M, UNIT_M}, '{UNIT_NONE, UNIT_NONE, UNIT_NONE}, '{UNIT_B, UNIT_F, UNIT_M},
    '{UNIT_NONE, UNIT_NONE, UNIT_NONE}
  };
endpackage

module btd_slot_decode import btd_pkg::*; (
  // slot in
  input btd_unit_e unit,
  input wire logic [SLOT_W-1:0] instr,
  input wire logic [PR_COUNT-1:0] predicateRegisters,
  // decode result
  output btd_op_e opClass,
  output btd_unit_e execUnit,
  output logic fault,
  output logic nop,
  output logic [IMM14_W-1:0] imm14,
  output logic imm14Valid
);
  logic [3:0] mop;
  logic guardTrue;
  logic ignUnused;
  logic resUnused;

  always_comb begin
    mop = instr[OPC_HI:OPC_LO]; // RULE12
    guardTrue = predicateRegisters[instr[QP_HI:QP_LO]];
    opClass = OP_UNUSED;
    execUnit = unit;
    ignUnused = 1'b0;
    resUnused = 1'b0;
    fault = 1'b0;
    nop = 1'b0;
    case (unit) // RULE13
      UNIT_I: begin
        case (mop) // RULE17
          MOP_0: opClass = OP_I_MISC;
          MOP_4: opClass = OP_DEPOSIT;
          MOP_5: opClass = OP_SHIFT_TBIT;
          MOP_7: opClass = OP_MM_MPY_SHIFT;
          MOP_8: opClass = OP_ALU; // RULE11
          MOP_9: opClass = OP_ADD_IMM22;
          MOP_C, MOP_D, MOP_E: opClass = OP_COMPARE;
          default: opClass = OP_UNUSED;
        endcase
      end
      UNIT_M: begin
        case (mop) // RULE18
          MOP_0, MOP_1: opClass = OP_MEM_MGMT;
          MOP_4: opClass = OP_INT_LD_REG;
          MOP_5: opClass = OP_INT_LDST_IMM;
          MOP_6: opClass = OP_FP_LDST_REG;
          MOP_7: opClass = OP_FP_LDST_IMM;
          MOP_8: opClass = OP_ALU; // RULE11
          MOP_9: opClass = OP_ADD_IMM22;
          MOP_C, MOP_D, MOP_E: opClass = OP_COMPARE;
          default: opClass = OP_UNUSED;
        endcase
      end
      UNIT_F: begin
        case (mop) // RULE19
          MOP_0, MOP_1: opClass = OP_FP_MISC;
          MOP_4: opClass = OP_FP_COMPARE;
          MOP_5: opClass = OP_FP_CLASS;
          MOP_8, MOP_9: opClass = OP_FMA;
          MOP_A, MOP_B: opClass = OP_FMS;
          MOP_C, MOP_D: opClass = OP_FNMA;
          MOP_E: opClass = OP_FSEL_XMA;
          default: opClass = OP_UNUSED;
        endcase
      end
      UNIT_B: begin
        ignUnused = UNUSED_IGN_B[mop];
        case (mop) // RULE20
          MOP_0: opClass = OP_B_MISC_IND;
          MOP_1: opClass = OP_IND_CALL;
          MOP_2: opClass = OP_B_NOP;
          MOP_4: opClass = OP_REL_BRANCH;
          MOP_5: opClass = OP_REL_CALL;
          default: opClass = OP_UNUSED;
        endcase
      end
      UNIT_X: begin
        execUnit = UNIT_I; // RULE9
        resUnused = UNUSED_RES_X[mop];
        case (mop) // RULE20
          MOP_0: opClass = OP_LX_MISC;
          MOP_6: opClass = OP_MOVL;
          default: opClass = OP_UNUSED;
        endcase
      end
      UNIT_L: begin
        // the immediate half of the pair; the op is decoded on the X slot
        opClass = OP_LX_PAIR; // RULE9
        execUnit = UNIT_I;
      end
      default: opClass = OP_NONE;
    endcase
    if (opClass == OP_UNUSED) begin
      if (ignUnused) begin
        nop = 1'b1; // RULE14
      end else if (resUnused) begin
        fault = 1'b1; // RULE15
      end else begin
        fault = guardTrue; // RULE16
        nop = !guardTrue; // RULE16
      end
    end
    if (opClass == OP_B_NOP) begin
      nop = 1'b1;
    end
    imm14 = {instr[SIGN_BIT], instr[IMM6_HI:IMM6_LO], instr[IMM7_HI:IMM7_LO]}; // RULE21
    imm14Valid = (opClass == OP_ALU) && (instr[X2A_HI:X2A_LO] >= X2A_ADD_IMM14); // RULE21
  end
endmodule // btd_slot_decode

//--- core/btd_bundle_decoder.sv
// bundle template and major opcode decoder, one registered stage
// Operation
// [RULE1] Accept each 128-bit bundle as three 41-bit slots and a 5-bit template.
// [RULE2] Template bits 4:0, slot 0 bits 45:5, slot 1 86:46, slot 2 127:87.
// [RULE3] Template yields both stop positions and the unit type of each slot.
// [RULE4] Slot 0 executes earliest and slot 2 latest within a bundle.
// [RULE5] Reserved templates 06,07,14,15,1A,1B,1E,1F raise an illegal operation fault.
// [RULE6] Templates 00-03 MII, 04-05 MLX, 08-0B MMI.
// [RULE7] Templates 0C-0D MFI, 0E-0F MMF, 10-11 MIB, 12-13 MBB.
// [RULE8] Templates 16-17 BBB, 18-19 MMB, 1C-1D MFB.
// [RULE9] Long-immediate instruction spans slots 1 and 2 and runs on the I unit.
// [RULE10] Integer to I, memory to M, floating-point to F, branch to B.
// [RULE11] Integer ALU instructions execute from either an I slot or an M slot.
// [RULE12] Instructions are 41 bits; major opcode is bits 40:37.
// [RULE13] Major opcode meaning depends on the unit column chosen by the template.
// [RULE14] Ignored unused major opcodes complete as no-ops without fault.
// [RULE15] Reserved unused major opcodes always raise an illegal operation fault.
// [RULE16] Guard-reserved opcodes fault if the guard predicate is 1, else no-op.
// [RULE17] I column 0,4,5,7,8,9,C-E: misc, deposit, shift, mm, ALU, add22, compare.
// [RULE18] M column: 0-1 mem mgmt, 4-7 loads/stores, 8 ALU, 9 add22, C-E compare.
// [RULE19] F column 0-1,4,5,8-9,A-B,C-D,E: misc, compare, class, fma, fms, fnma, select.
// [RULE20] B column 0,1,2,4,5: misc, call, nop, branch, call; extended 0 misc, 6 movl.
// [RULE21] Add-immediate-14 immediate is sign bit, 6-bit and 7-bit fields.
module btd_bundle_decoder import btd_pkg::*; #(
  // templates whose stop falls after slot 0 / slot 1, one bit per template value
  parameter logic [31:0] STOP_AFTER_SLOT0 = 32'h0000_0000,
  parameter logic [31:0] STOP_AFTER_SLOT1 = 32'h0000_0000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // from fetch
  input wire logic bundleValid,
  input wire logic [BUNDLE_W-1:0] bundle,
  input wire logic [PR_COUNT-1:0] predicateRegisters,
  // bundle-level result
  output logic decValid,
  output logic [TPL_W-1:0] templateValue,
  output logic templateFault,
  output logic [SLOT_COUNT-1:0] stopAfter,
  output logic bundleFault,
  output logic [SEL_W-1:0] firstFaultSlot,
  // per-slot result to execution units
  output btd_trio_t slotUnit,
  output btd_trio_t slotExecUnit,
  output btd_op_e [SLOT_COUNT-1:0] slotOp,
  output logic [SLOT_COUNT-1:0] slotFault,
  output logic [SLOT_COUNT-1:0] slotNop,
  output logic [SLOT_COUNT-1:0][SLOT_W-1:0] slotInstr,
  output logic [SLOT_COUNT-1:0][IMM14_W-1:0] slotImm14,
  output logic [SLOT_COUNT-1:0] slotImm14Valid
);
  typedef struct packed {
    logic valid;
    logic [TPL_W-1:0] tmpl;
    logic tplFault;
    logic [SLOT_COUNT-1:0] stop;
    logic anyFault;
    logic [SEL_W-1:0] firstFault;
    btd_trio_t unit;
    btd_trio_t execUnit;
    btd_op_e [SLOT_COUNT-1:0] op;
    logic [SLOT_COUNT-1:0] fault;
    logic [SLOT_COUNT-1:0] nop;
    logic [SLOT_COUNT-1:0][SLOT_W-1:0] instr;
    logic [SLOT_COUNT-1:0][IMM14_W-1:0] imm;
    logic [SLOT_COUNT-1:0] immValid;
  } btd_state_s;

  btd_state_s state_q;
  btd_state_s state_d;

  logic [TPL_W-1:0] tmplIn;
  btd_trio_t unitIn;
  logic [SLOT_COUNT-1:0][SLOT_W-1:0] slotIn;
  btd_op_e [SLOT_COUNT-1:0] opIn;
  btd_trio_t execIn;
  logic [SLOT_COUNT-1:0] faultIn;
  logic [SLOT_COUNT-1:0] nopIn;
  logic [SLOT_COUNT-1:0][IMM14_W-1:0] immIn;
  logic [SLOT_COUNT-1:0] immValidIn;

  assign tmplIn = bundle[TPL_LO +: TPL_W]; // RULE2
  // reserved templates map to no unit, so no slot decodes behind them
  assign unitIn = TPL_PAIR_MAP[tmplIn[TPL_W-1:1]]; // RULE6 RULE7 RULE8

  // one decoder per slot; the column comes from the template
  for (genvar k = 0; k < SLOT_COUNT; k++) begin : g_slot
    assign slotIn[k] = bundle[SLOT0_LO + k*SLOT_W +: SLOT_W]; // RULE1 RULE2
    btd_slot_decode u_dec (
      .unit(unitIn[k]),
      .instr(slotIn[k]),
      .predicateRegisters(predicateRegisters),
      .opClass(opIn[k]),
      .execUnit(execIn[k]),
      .fault(faultIn[k]),
      .nop(nopIn[k]),
      .imm14(immIn[k]),
      .imm14Valid(immValidIn[k])
    ); // RULE10 RULE13
  end

  always_comb begin
    state_d = state_q;
    state_d.valid = bundleValid;
    state_d.tmpl = tmplIn;
    state_d.tplFault = bundleValid && TPL_RESERVED[tmplIn]; // RULE5
    state_d.stop = {tmplIn[0], STOP_AFTER_SLOT1[tmplIn], STOP_AFTER_SLOT0[tmplIn]}; // RULE3
    state_d.unit = unitIn; // RULE3
    state_d.execUnit = execIn;
    state_d.op = opIn;
    state_d.fault = bundleValid ? faultIn : NO_SLOTS;
    state_d.nop = bundleValid ? nopIn : NO_SLOTS;
    state_d.instr = slotIn;
    state_d.imm = immIn;
    state_d.immValid = bundleValid ? immValidIn : NO_SLOTS;
    state_d.anyFault = state_d.tplFault || (|state_d.fault);
    // lowest slot wins: it is the earliest in execution order
    state_d.firstFault = SLOT_SEL_0;
    for (int k = SLOT_COUNT - 1; k >= 0; k--) begin
      if (state_d.fault[k]) begin
        state_d.firstFault = SEL_W'(k); // RULE4
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign decValid = state_q.valid;
  assign templateValue = state_q.tmpl;
  assign templateFault = state_q.tplFault;
  assign stopAfter = state_q.stop;
  assign bundleFault = state_q.anyFault;
  assign firstFaultSlot = state_q.firstFault;
  assign slotUnit = state_q.unit;
  assign slotExecUnit = state_q.execUnit;
  assign slotOp = state_q.op;
  assign slotFault = state_q.fault;
  assign slotNop = state_q.nop;
  assign slotInstr = state_q.instr;
  assign slotImm14 = state_q.imm;
  assign slotImm14Valid = state_q.immValid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  valid_latency_a: assert property (bundleValid |=> decValid ##0 $past(bundleValid)) // RULE1
    else $error("decoded valid does not follow bundle valid by one cycle");

  slot_split_a: assert property (bundleValid |=> // RULE2
    slotInstr[2] == $past(bundle[SLOT0_LO + 2*SLOT_W +: SLOT_W]) && templateValue == $past(bundle[TPL_LO +: TPL_W]))
    else $error("bundle not split into template and slots");

  stop_end_a: assert property (decValid |-> stopAfter[SLOT_COUNT-1] == templateValue[0]) // RULE3
    else $error("end stop does not match template");

  first_fault_a: assert property (decValid && slotFault[1] && !slotFault[0] |-> firstFaultSlot == SEL_W'(1)) // RULE4
    else $error("earliest faulting slot not reported");

  tpl_reserved_a: assert property (bundleValid && TPL_RESERVED[tmplIn] |=> templateFault && bundleFault) // RULE5
    else $error("reserved template did not fault");

  mlx_route_a: assert property (bundleValid && unitIn[1] == UNIT_L |=> // RULE9
    slotUnit[2] == UNIT_X && slotExecUnit[1] == UNIT_I && slotExecUnit[2] == UNIT_I)
    else $error("extended pair not routed to the I unit");

  alu_m_slot_a: assert property (bundleValid && unitIn[0] == UNIT_M &&
    slotIn[0][OPC_HI:OPC_LO] == MOP_8 |=> slotOp[0] == OP_ALU) // RULE11
    else $error("ALU opcode in M slot not decoded as ALU");

  unused_split_a: assert property (decValid && slotOp[2] == OP_UNUSED |-> slotFault[2] != slotNop[2]) // RULE16
    else $error("unused opcode neither faulted nor completed as nop");

  fault_sum_a: assert property (decValid |-> bundleFault == (templateFault || (|slotFault))) // RULE15
    else $error("bundle fault disagrees with slot faults");

  x_reserved_a: assert property (bundleValid && unitIn[2] == UNIT_X && // RULE15
    UNUSED_RES_X[slotIn[2][OPC_HI:OPC_LO]] |=> slotFault[2] && !slotNop[2] && bundleFault)
    else $error("reserved extended opcode did not fault");

  b_ignored_a: assert property (bundleValid && unitIn[2] == UNIT_B && // RULE14
    UNUSED_IGN_B[slotIn[2][OPC_HI:OPC_LO]] |=> slotNop[2] && !slotFault[2])
    else $error("ignored branch opcode did not complete as nop");

  imm14_build_a: assert property (slotImm14Valid[0] |-> slotOp[0] == OP_ALU && // RULE21
    slotImm14[0] == {slotInstr[0][SIGN_BIT], slotInstr[0][IMM6_HI:IMM6_LO], slotInstr[0][IMM7_HI:IMM7_LO]})
    else $error("14-bit immediate wrongly assembled");
endmodule // btd_bundle_decoder

//--- sim/btd_fetch_model.sv
// fetch front-end model that presents bundles and predicates to the decoder
module btd_fetch_model import btd_pkg::*; (
  // clock
  input wire logic clk,
  // to decoder
  output logic bundleValid,
  output logic [BUNDLE_W-1:0] bundle,
  output logic [PR_COUNT-1:0] predicateRegisters
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    bundleValid = 1'b0;
    bundle = '0;
    predicateRegisters = '0;
  end

  // entered just after an edge; returns just after the edge that takes the bundle
  task automatic present(input logic [BUNDLE_W-1:0] b, input logic [PR_COUNT-1:0] pr);
    bundleValid = 1'b1;
    bundle = b;
    predicateRegisters = pr;
    @(posedge clk);
    #1;
  endtask

  // idle lines flip so a stale bundle can never pass for a fresh one; costs one cycle
  task automatic idle();
    bundleValid = 1'b0;
    bundle = ~bundle;
    predicateRegisters = ~predicateRegisters;
    @(posedge clk);
    #1;
  endtask
endmodule // btd_fetch_model

//--- sim/tb.sv
// self-checking bench for the bundle template decoder
module tb import btd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] STOP0 = 32'h0000_0400;
  localparam logic [31:0] STOP1 = 32'h0000_0008;
  localparam btd_op_e UNU = OP_UNUSED;
  localparam btd_op_e OPS_I [16] = '{OP_I_MISC, UNU, UNU, UNU, OP_DEPOSIT, OP_SHIFT_TBIT, UNU, OP_MM_MPY_SHIFT,
    OP_ALU, OP_ADD_IMM22, UNU, UNU, OP_COMPARE, OP_COMPARE, OP_COMPARE, UNU};
  localparam btd_op_e OPS_M [16] = '{OP_MEM_MGMT, OP_MEM_MGMT, UNU, UNU, OP_INT_LD_REG, OP_INT_LDST_IMM,
    OP_FP_LDST_REG, OP_FP_LDST_IMM, OP_ALU, OP_ADD_IMM22, UNU, UNU, OP_COMPARE, OP_COMPARE, OP_COMPARE, UNU};
  localparam btd_op_e OPS_F [16] = '{OP_FP_MISC, OP_FP_MISC, UNU, UNU, OP_FP_COMPARE, OP_FP_CLASS, UNU, UNU,
    OP_FMA, OP_FMA, OP_FMS, OP_FMS, OP_FNMA, OP_FNMA, OP_FSEL_XMA, UNU};
  localparam btd_op_e OPS_B [16] = '{OP_B_MISC_IND, OP_IND_CALL, OP_B_NOP, UNU, OP_REL_BRANCH, OP_REL_CALL,
    UNU, UNU, UNU, UNU, UNU, UNU, UNU, UNU, UNU, UNU};
  localparam btd_op_e OPS_X [16] = '{OP_LX_MISC, UNU, UNU, UNU, UNU, UNU, OP_MOVL, UNU,
    UNU, UNU, UNU, UNU, UNU, UNU, UNU, UNU};
  // three letters per template, slot 0 first; dashes mark reserved templates
  localparam string TMAP = {"MIIMIIMIIMIIMLXMLX------MMIMMIMMIMMIMFIMFIMMFMMF",
    "MIBMIBMBBMBB------BBBBBBMMBMMB------MFBMFB------"};
  localparam string UNITS = "-MIFBLX";

  logic clk;
  logic reset;
  logic bundleValid;
  logic [BUNDLE_W-1:0] bundle;
  logic [PR_COUNT-1:0] predicateRegisters;
  logic decValid;
  logic [TPL_W-1:0] templateValue;
  logic templateFault;
  logic [SLOT_COUNT-1:0] stopAfter;
  logic bundleFault;
  logic [SEL_W-1:0] firstFaultSlot;
  btd_trio_t slotUnit;
  btd_trio_t slotExecUnit;
  btd_op_e [SLOT_COUNT-1:0] slotOp;
  logic [SLOT_COUNT-1:0] slotFault;
  logic [SLOT_COUNT-1:0] slotNop;
  logic [SLOT_COUNT-1:0][SLOT_W-1:0] slotInstr;
  logic [SLOT_COUNT-1:0][IMM14_W-1:0] slotImm14;
  logic [SLOT_COUNT-1:0] slotImm14Valid;
  int err_count = 0;
  int checked = 0;

  btd_fetch_model fetch (.clk(clk), .bundleValid(bundleValid), .bundle(bundle),
    .predicateRegisters(predicateRegisters));

  btd_bundle_decoder #(.STOP_AFTER_SLOT0(STOP0), .STOP_AFTER_SLOT1(STOP1)) uut (.clk(clk), .reset(reset),
    .bundleValid(bundleValid), .bundle(bundle), .predicateRegisters(predicateRegisters), .decValid(decValid),
    .templateValue(templateValue), .templateFault(templateFault), .stopAfter(stopAfter),
    .bundleFault(bundleFault), .firstFaultSlot(firstFaultSlot), .slotUnit(slotUnit),
    .slotExecUnit(slotExecUnit), .slotOp(slotOp), .slotFault(slotFault), .slotNop(slotNop),
    .slotInstr(slotInstr), .slotImm14(slotImm14), .slotImm14Valid(slotImm14Valid));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic btd_unit_e unit_of(input byte c);
    btd_unit_e r;
    r = UNIT_NONE;
    for (int i = 0; i < 7; i++) begin
      if (UNITS[i] == c) begin
        r = btd_unit_e'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [SLOT_W-1:0] ins(input logic [3:0] m, input logic [5:0] qp);
    return {m, 31'h0000_0000, qp};
  endfunction

  // judges one slot of the current result against its unit column
  task automatic check_slot(input int s, input byte c, input logic [3:0] m, input logic hit, output logic f);
    btd_op_e op;
    logic unused;
    logic nop;
    case (c)
      "I": op = OPS_I[m];
      "M": op = OPS_M[m];
      "F": op = OPS_F[m];
      "B": op = OPS_B[m];
      default: op = OPS_X[m];
    endcase
    unused = (op == UNU);
    f = (c == "B") ? 1'b0 : (c == "X") ? unused : unused & hit;
    nop = (c == "B") ? (unused | m == 4'h2) : (c != "X") & unused & !hit;
    check("slotOp", slotOp[s], op);
    check("slotFault", slotFault[s], f);
    check("slotNop", slotNop[s], nop);
  endtask

  task automatic test_templates();
    logic [SLOT_W-1:0] s0, s1, s2;
    logic [4:0] t;
    logic res;
    byte c;
    s0 = {4'h0, 37'h1_2345_6789};
    s1 = {4'h0, 37'h0_ABCD_EF01};
    s2 = {4'h0, 37'h1_0F0F_0F0F};
    for (int i = 0; i < 32; i++) begin
      t = 5'(i);
      res = TMAP[i * 3] == "-";
      fetch.present({s2, s1, s0, t}, '0);
      check("decValid", decValid, 1'b1);
      check("templateValue", templateValue, t);
      check("templateFault", templateFault, res);
      check("bundleFault", bundleFault, res);
      check("slotFault", slotFault, NO_SLOTS);
      check("slotInstr0", slotInstr[0], s0);
      check("slotInstr1", slotInstr[1], s1);
      check("slotInstr2", slotInstr[2], s2);
      if (!res) begin
        check("stopAfter", stopAfter, {t[0], STOP1[t], STOP0[t]});
      end
      for (int s = 0; s < 3; s++) begin
        c = TMAP[i * 3 + s];
        check("slotUnit", slotUnit[s], unit_of(c));
        check("slotExecUnit", slotExecUnit[s], unit_of((c == "L" || c == "X") ? "I" : c));
      end
    end
    fetch.idle();
    check("decValidIdle", decValid, 1'b0);
    check("slotNopIdle", slotNop, NO_SLOTS);
    $display("test_templates done");
  endtask

  task automatic test_opcodes();
    logic [4:0] tl [3];
    logic [SLOT_W-1:0] w;
    logic [PR_COUNT-1:0] pr;
    logic f;
    logic any;
    logic [SEL_W-1:0] first;
    byte c;
    tl = '{5'h0C, 5'h16, 5'h04};
    for (int h = 0; h < 2; h++) begin
      // guard predicate 37 alone set, then everything but 37 set
      pr = (h == 0) ? 64'h0000_0020_0000_0000 : 64'hFFFF_FFDF_FFFF_FFFF;
      for (int m = 0; m < 16; m++) begin
        for (int k = 0; k < 3; k++) begin
          w = ins(4'(m), 6'h25);
          fetch.present({w, w, w, tl[k]}, pr);
          any = 1'b0;
          first = SLOT_SEL_0;
          for (int s = 2; s >= 0; s--) begin
            c = TMAP[tl[k] * 3 + s];
            if (c == "L") begin
              check("slotOpPair", slotOp[s], OP_LX_PAIR);
            end else begin
              check_slot(s, c, 4'(m), pr[37], f);
              any = any | f;
              first = f ? SEL_W'(s) : first;
            end
          end
          check("bundleFault", bundleFault, any);
          check("firstFaultSlot", firstFaultSlot, first);
        end
      end
    end
    $display("test_opcodes done");
  endtask

  task automatic test_imm14();
    logic [SLOT_W-1:0] w;
    logic [IMM14_W-1:0] imm;
    logic v;
    for (int x = 0; x < 4; x++) begin
      w = {4'h8, x[0], 2'(x), 1'b0, 6'h2D, 7'h00, 7'h55, 13'h0000};
      imm = {x[0], 6'h2D, 7'h55};
      v = x >= 2;
      fetch.present({w, w, w, 5'h08}, '0);
      for (int s = 0; s < 3; s++) begin
        check("slotOpAlu", slotOp[s], OP_ALU);
        check("slotImm14Valid", slotImm14Valid[s], v);
        if (v) begin
          check("slotImm14", slotImm14[s], imm);
        end
      end
    end
    $display("test_imm14 done");
  endtask

  task automatic test_reset();
    logic [SLOT_W-1:0] w;
    w = ins(4'h3, 6'h25);
    reset = 1'b1;
    fetch.present({w, w, w, 5'h06}, '1);
    check("decValidReset", decValid, 1'b0);
    check("templateFaultReset", templateFault, 1'b0);
    reset = 1'b0;
    fetch.present({w, w, w, 5'h06}, '1);
    check("templateFault", templateFault, 1'b1);
    check("slotFault", slotFault, NO_SLOTS);
    check("slotUnit", slotUnit, 9'h000);
    fetch.idle();
    $display("test_reset done");
  endtask

  initial begin
    reset = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    check("decValidHeld", decValid, 1'b0);
    check("slotOpHeld", slotOp, 15'h0000);
    reset = 1'b0;
    test_templates();
    test_opcodes();
    test_imm14();
    test_reset();
    print_verdict();
  end

  // hang guard: the whole run needs about 150 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule // tb
